/* aoftp_params.svh */
// register offsets, field positions, reset values and pattern constants for the output format block
`ifndef AOFTP_PARAMS_SVH
`define AOFTP_PARAMS_SVH
`define AOFTP_OFS_FMT        8'h73
`define AOFTP_OFS_TIMING     8'h74
`define AOFTP_OFS_CAL        8'hB6
`define AOFTP_OFS_TEST       8'hC0
`define AOFTP_OFS_UPAT1_LO   8'hC1
`define AOFTP_RST_FMT        8'h00
`define AOFTP_RST_TIMING     8'h00
`define AOFTP_RST_TEST       8'h00
`define AOFTP_RST_UPAT       8'h00
`define AOFTP_FMT_DRIVE_HI   7
`define AOFTP_FMT_DRIVE_LO   5
`define AOFTP_FMT_CODE_HI    2
`define AOFTP_FMT_CODE_LO    0
`define AOFTP_TIM_DLL_BIT    6
`define AOFTP_TIM_DDR_BIT    4
`define AOFTP_CAL_DONE_BIT   0
`define AOFTP_TST_MODE_HI    7
`define AOFTP_TST_MODE_LO    4
`define AOFTP_TST_SEQ_HI     2
`define AOFTP_TST_SEQ_LO     0
`define AOFTP_MIDSCALE       12'h800
`define AOFTP_POS_FS         12'hFFF
`define AOFTP_NEG_FS         12'h000
`define AOFTP_CHECKER        12'hAAA
`define AOFTP_FIFO_DEPTH     8
`endif

/* aoftp_pkg.sv */
// types shared by the output format and test pattern block
package aoftp_pkg;
    typedef enum logic [2:0] {
        AOFTP_DRV_LVDS3 = 3'h0,
        AOFTP_DRV_LVDS2 = 3'h1,
        AOFTP_DRV_CMOS  = 3'h4
    } aoftp_drive_t;
    typedef enum logic [2:0] {
        AOFTP_COD_TWOS = 3'h0,
        AOFTP_COD_GRAY = 3'h2,
        AOFTP_COD_OBIN = 3'h4
    } aoftp_code_t;
    typedef enum logic [3:0] {
        AOFTP_TM_OFF   = 4'h0,
        AOFTP_TM_MID   = 4'h1,
        AOFTP_TM_PFS   = 4'h2,
        AOFTP_TM_NFS   = 4'h3,
        AOFTP_TM_CHK   = 4'h4,
        AOFTP_TM_ALT   = 4'h7,
        AOFTP_TM_USER  = 4'h8,
        AOFTP_TM_RAMP  = 4'hA
    } aoftp_test_t;
    typedef struct packed {
        logic       we;
        logic       re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } aoftp_reg_req_t;
    typedef struct packed {
        logic        ddr;
        logic [11:0] data;
    } aoftp_word_t;
    typedef struct packed {
        logic [2:0] drive;
        logic       ddr;
        logic       dll_slow;
    } aoftp_port_cfg_t;
endpackage : aoftp_pkg

/* aoftp_fifo.sv */
// parameterised flop fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module aoftp_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    input  wire logic             SYS_CLK,
    input  wire logic             RESET,
    input  wire logic             IN_VALID,
    output var  logic             IN_READY,
    input  wire logic [WIDTH-1:0] IN_DATA,
    output var  logic             OUT_VALID,
    input  wire logic             OUT_READY,
    output var  logic [WIDTH-1:0] OUT_DATA
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    always_comb
    begin
        // full compare needs the extra count bit; a depth cast to AW bits wraps to zero
        push = IN_VALID && (cnt_q != (AW+1)'(DEPTH));
        pop  = OUT_READY && (cnt_q != '0);
        wp_d = push ? AW'(wp_q + 1'b1) : wp_q;
        rp_d = pop ? AW'(rp_q + 1'b1) : rp_q;
        cnt_d = (AW+1)'(cnt_q + push - pop);
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
        if (push)
            mem_q[wp_q] <= IN_DATA;
    end

    assign IN_READY  = (cnt_q != (AW+1)'(DEPTH));
    assign OUT_VALID = (cnt_q != '0);
    assign OUT_DATA  = mem_q[rp_q];
endmodule : aoftp_fifo
`default_nettype wire

/* aoftp_top.sv */
// output format, timing and test pattern control for the converter output port
`timescale 1ns/10ps
`default_nettype none
`include "aoftp_params.svh"
module aoftp_top (
    input  wire logic                     SYS_CLK,
    input  wire logic                     RESET,
    input  wire logic                     SOFT_RESET,
    input  wire aoftp_pkg::aoftp_reg_req_t REG_REQ,
    output var  logic [7:0]               REG_RDATA,
    input  wire logic                     CAL_DONE_IN,
    input  wire logic                     SAMPLE_VALID,
    output var  logic                     SAMPLE_READY,
    input  wire logic [11:0]              SAMPLE_IN,
    output var  logic                     OUT_VALID,
    input  wire logic                     OUT_READY,
    output var  aoftp_pkg::aoftp_word_t   OUT_WORD,
    output var  aoftp_pkg::aoftp_port_cfg_t PORT_CFG
);
    import aoftp_pkg::*;

    logic [7:0]  fmt_q, fmt_d, tim_q, tim_d, tst_q, tst_d, up1_q, up1_d;
    logic [7:0]  rdata_q, rdata_d;
    logic        cal_s1_q, cal_s2_q;
    logic [2:0]  seq_q, seq_d;
    logic [11:0] ramp_q, ramp_d;
    logic        alt_q, alt_d;
    logic [11:0] pat, coded;
    logic        fifo_in_ready, fifo_out_valid;
    aoftp_word_t fifo_out;
    aoftp_word_t word_q, word_d;
    logic        ovalid_q, ovalid_d;
    logic        sready_q;
    aoftp_port_cfg_t cfg_q, cfg_d;
    logic [3:0]  tmode;
    logic [2:0]  useq;
    logic        ddr, adv;
    logic [2:0]  seq_last;

    always_comb
    begin
        fmt_d = fmt_q;
        tim_d = tim_q;
        tst_d = tst_q;
        up1_d = up1_q;
        // output-mode registers deliberately ignore soft reset
        if (REG_REQ.we && REG_REQ.addr == `AOFTP_OFS_FMT)
            fmt_d = REG_REQ.wdata;
        if (REG_REQ.we && REG_REQ.addr == `AOFTP_OFS_TIMING)
            tim_d = REG_REQ.wdata;
        if (SOFT_RESET)
        begin
            tst_d = `AOFTP_RST_TEST;
            up1_d = `AOFTP_RST_UPAT;
        end
        else
        begin
            if (REG_REQ.we && REG_REQ.addr == `AOFTP_OFS_TEST)
                tst_d = REG_REQ.wdata;
            if (REG_REQ.we && REG_REQ.addr == `AOFTP_OFS_UPAT1_LO)
                up1_d = REG_REQ.wdata;
        end
        rdata_d = 8'h00;
        case (REG_REQ.addr)
            `AOFTP_OFS_FMT:      rdata_d = fmt_q;
            `AOFTP_OFS_TIMING:   rdata_d = tim_q;
            `AOFTP_OFS_CAL:      rdata_d = {7'h00, cal_s2_q};
            `AOFTP_OFS_TEST:     rdata_d = tst_q;
            `AOFTP_OFS_UPAT1_LO: rdata_d = up1_q;
            default:             rdata_d = 8'h00;
        endcase
        if (!REG_REQ.re)
            rdata_d = rdata_q;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            fmt_q    <= `AOFTP_RST_FMT;
            tim_q    <= `AOFTP_RST_TIMING;
            tst_q    <= `AOFTP_RST_TEST;
            up1_q    <= `AOFTP_RST_UPAT;
            rdata_q  <= 8'h00;
            cal_s1_q <= 1'b0;
            cal_s2_q <= 1'b0;
        end
        else
        begin
            fmt_q    <= fmt_d;
            tim_q    <= tim_d;
            tst_q    <= tst_d;
            up1_q    <= up1_d;
            rdata_q  <= rdata_d;
            cal_s1_q <= CAL_DONE_IN;
            cal_s2_q <= cal_s1_q;
        end
    end

    // only pattern one's low byte is stored; other user words read as zero
    always_comb
    begin
        tmode    = tst_q[`AOFTP_TST_MODE_HI:`AOFTP_TST_MODE_LO];
        useq     = tst_q[`AOFTP_TST_SEQ_HI:`AOFTP_TST_SEQ_LO];
        ddr      = tim_q[`AOFTP_TIM_DDR_BIT];
        adv      = fifo_in_ready && SAMPLE_VALID;
        // ddr steps odd patterns; sequence index counts in pairs
        seq_last = ddr ? ((useq > 3'h3) ? 3'h0 : 3'(useq << 1)) : useq;
        seq_d    = seq_q;
        // new test or rate setting restarts at pattern one; a stale index would skip it
        if (SOFT_RESET || (REG_REQ.we && (REG_REQ.addr == `AOFTP_OFS_TEST || REG_REQ.addr == `AOFTP_OFS_TIMING)))
            seq_d = 3'h0;
        else if (adv)
        begin
            if (seq_q >= seq_last)
                seq_d = 3'h0;
            else
                seq_d = ddr ? 3'(seq_q + 3'h2) : 3'(seq_q + 3'h1);
        end
        ramp_d = adv ? 12'(ramp_q + 12'h001) : ramp_q;
        alt_d  = adv ? ~alt_q : alt_q;
        case (tmode)
            AOFTP_TM_MID:  pat = `AOFTP_MIDSCALE;
            AOFTP_TM_PFS:  pat = `AOFTP_POS_FS;
            AOFTP_TM_NFS:  pat = `AOFTP_NEG_FS;
            AOFTP_TM_CHK:  pat = ddr ? SAMPLE_IN : (alt_q ? ~`AOFTP_CHECKER : `AOFTP_CHECKER);
            AOFTP_TM_ALT:  pat = ddr ? SAMPLE_IN : {12{alt_q}};
            AOFTP_TM_USER: pat = (seq_q == 3'h0) ? {4'h0, up1_q} : 12'h000;
            AOFTP_TM_RAMP: pat = ramp_q;
            default:       pat = SAMPLE_IN;
        endcase
        case (fmt_q[`AOFTP_FMT_CODE_HI:`AOFTP_FMT_CODE_LO])
            AOFTP_COD_GRAY: coded = pat ^ {1'b0, pat[11:1]};
            AOFTP_COD_OBIN: coded = {~pat[11], pat[10:0]};
            default:        coded = pat;
        endcase
        word_d   = word_q;
        ovalid_d = ovalid_q;
        if (!ovalid_q || OUT_READY)
        begin
            ovalid_d = fifo_out_valid;
            word_d   = fifo_out;
        end
        cfg_d.drive    = fmt_q[`AOFTP_FMT_DRIVE_HI:`AOFTP_FMT_DRIVE_LO];
        cfg_d.ddr      = ddr;
        cfg_d.dll_slow = tim_q[`AOFTP_TIM_DLL_BIT];
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            seq_q    <= 3'h0;
            ramp_q   <= 12'h000;
            alt_q    <= 1'b0;
            word_q   <= '0;
            ovalid_q <= 1'b0;
            cfg_q    <= '0;
            sready_q <= 1'b0;
        end
        else
        begin
            seq_q    <= seq_d;
            ramp_q   <= ramp_d;
            alt_q    <= alt_d;
            word_q   <= word_d;
            ovalid_q <= ovalid_d;
            cfg_q    <= cfg_d;
            sready_q <= fifo_in_ready;
        end
    end

    aoftp_fifo #(.WIDTH(13), .DEPTH(`AOFTP_FIFO_DEPTH)) u_fifo (
        .SYS_CLK   (SYS_CLK),
        .RESET     (RESET),
        .IN_VALID  (SAMPLE_VALID),
        .IN_READY  (fifo_in_ready),
        .IN_DATA   ({ddr, coded}),
        .OUT_VALID (fifo_out_valid),
        .OUT_READY (!ovalid_q || OUT_READY),
        .OUT_DATA  (fifo_out)
    );

    assign REG_RDATA    = rdata_q;
    assign SAMPLE_READY = sready_q;
    assign OUT_VALID    = ovalid_q;
    assign OUT_WORD     = word_q;
    assign PORT_CFG     = cfg_q;

    AST_FMT_SOFT: assert property (@(posedge SYS_CLK) disable iff (RESET)
        SOFT_RESET && !REG_REQ.we |=> fmt_q == $past(fmt_q) && tim_q == $past(tim_q))
        else $error("output mode changed by soft reset");
    AST_RST_ZERO: assert property (@(posedge SYS_CLK) disable iff (RESET)
        $past(RESET) |-> fmt_q == 8'h00 && tim_q == 8'h00)
        else $error("output mode not zero after reset");
    AST_DRIVE: assert property (@(posedge SYS_CLK) disable iff (RESET)
        ##1 cfg_q.drive == $past(fmt_q[7:5]))
        else $error("drive field not applied");
    AST_DLL: assert property (@(posedge SYS_CLK) disable iff (RESET)
        ##1 cfg_q.dll_slow == $past(tim_q[6]))
        else $error("dll range not applied");
    AST_DDR: assert property (@(posedge SYS_CLK) disable iff (RESET)
        ##1 cfg_q.ddr == $past(tim_q[4]))
        else $error("ddr enable not applied");
    AST_SEQ0: assert property (@(posedge SYS_CLK) disable iff (RESET)
        useq == 3'h0 |=> seq_q == 3'h0 || $past(useq) != 3'h0)
        else $error("sequence 0 left pattern one");
    AST_SEQ_BOUND: assert property (@(posedge SYS_CLK) disable iff (RESET)
        !ddr && $stable(tst_q) && $past(seq_q) <= useq |-> seq_q <= useq)
        else $error("sdr sequence past last pattern");
    AST_DDR_ODD: assert property (@(posedge SYS_CLK) disable iff (RESET)
        ddr && $stable(tim_q) && !$past(seq_q[0]) && adv |=> !seq_q[0])
        else $error("ddr sequence hit even pattern");
    AST_CAL_RO: assert property (@(posedge SYS_CLK) disable iff (RESET)
        REG_REQ.re && REG_REQ.addr == 8'hB6 |=> REG_RDATA[7:1] == 7'h00 && REG_RDATA[0] == $past(cal_s2_q))
        else $error("calibration status wrong");
endmodule : aoftp_top
`default_nettype wire

/* aoftp_capture.sv */
// capture model of the logic receiving the output port words
`timescale 1ns/10ps
`default_nettype none
module aoftp_capture (
    input  wire logic              SYS_CLK,
    input  wire logic              RESET,
    input  wire logic              STALL,
    input  wire logic              SLOW,
    input  wire logic              OUT_VALID,
    output var  logic              OUT_READY,
    input  wire aoftp_pkg::aoftp_word_t OUT_WORD
);
    import aoftp_pkg::*;
    logic        ph_q;
    aoftp_word_t got[$];
    // slow mode accepts every other cycle to exercise back-pressure
    assign OUT_READY = !STALL && (!SLOW || ph_q);
    always_ff @(posedge SYS_CLK)
    begin
        ph_q <= RESET ? 1'b0 : ~ph_q;
        if (!RESET && OUT_VALID && OUT_READY)
            got.push_back(OUT_WORD);
    end
endmodule : aoftp_capture
`default_nettype wire

/* aoftp_tb.sv */
// self-checking testbench for the output format and test pattern block
`timescale 1ns/10ps
`default_nettype none
`include "aoftp_params.svh"
module testbench;
    import aoftp_pkg::*;
    logic sys_clk, reset, soft_reset, cal_done_in, sample_valid, stall, slow;
    logic sample_ready, out_valid, out_ready;
    logic [7:0] rdata, rd;
    logic [11:0] sample_in;
    aoftp_reg_req_t req;
    aoftp_word_t out_word;
    aoftp_port_cfg_t port_cfg;
    int error_cnt = 0;
    int cmp_count = 0;
    aoftp_top DUT (.SYS_CLK(sys_clk), .RESET(reset), .SOFT_RESET(soft_reset), .REG_REQ(req),
        .REG_RDATA(rdata), .CAL_DONE_IN(cal_done_in), .SAMPLE_VALID(sample_valid),
        .SAMPLE_READY(sample_ready), .SAMPLE_IN(sample_in), .OUT_VALID(out_valid),
        .OUT_READY(out_ready), .OUT_WORD(out_word), .PORT_CFG(port_cfg));
    aoftp_capture cap (.SYS_CLK(sys_clk), .RESET(reset), .STALL(stall), .SLOW(slow),
        .OUT_VALID(out_valid), .OUT_READY(out_ready), .OUT_WORD(out_word));
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [12:0] act, input logic [12:0] exp, input string msg);
        cmp_count++;
        if (act !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, act, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        req = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(negedge sys_clk);
        req = '0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        req = '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
        @(negedge sys_clk);
        req = '0;
        @(negedge sys_clk);
        chk({5'h00, rdata}, {5'h00, exp}, "register read");
    endtask : rdchk
    // only counts samples offered while ready, so the source never overruns
    task automatic run(input logic [7:0] test_byte, input int n);
        int i;
        int k;
        wr(`AOFTP_OFS_TEST, test_byte);
        cap.got.delete();
        i = 0;
        for (k = 0; k < 200 && i < n; k++)
        begin
            @(negedge sys_clk);
            sample_valid = sample_ready;
            sample_in = 12'h123 + 12'(i);
            if (sample_ready)
                i++;
        end
        @(negedge sys_clk);
        sample_valid = 1'b0;
        repeat (40) @(negedge sys_clk);
        chk(13'(cap.got.size()), 13'(n), "word count");
    endtask : run
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    initial
    begin
        #200000;
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim();
    end
    initial
    begin
        logic [11:0] fixed_val [3] = '{`AOFTP_MIDSCALE, `AOFTP_POS_FS, `AOFTP_NEG_FS};
        reset = 1'b1;
        soft_reset = 1'b0;
        cal_done_in = 1'b0;
        sample_valid = 1'b0;
        sample_in = 12'h000;
        stall = 1'b0;
        slow = 1'b0;
        req = '0;
        repeat (4) @(negedge sys_clk);
        reset = 1'b0;
        foreach (fixed_val[j]) rdchk(8'h73 + 8'(j), 8'h00);
        rdchk(`AOFTP_OFS_TEST, `AOFTP_RST_TEST);
        rdchk(8'h80, 8'h00);
        chk({8'h00, port_cfg}, 13'h0000, "port config reset");
        $display("test reset values done");
        wr(`AOFTP_OFS_FMT, 8'h82);
        wr(`AOFTP_OFS_TIMING, 8'h40);
        rdchk(`AOFTP_OFS_FMT, 8'h82);
        chk({10'h000, port_cfg.drive}, 13'(AOFTP_DRV_CMOS), "cmos drive");
        chk({12'h000, port_cfg.dll_slow}, 13'h0001, "dll slow");
        wr(`AOFTP_OFS_FMT, 8'h20);
        @(negedge sys_clk);
        chk({10'h000, port_cfg.drive}, 13'(AOFTP_DRV_LVDS2), "lvds 2mA");
        wr(`AOFTP_OFS_TEST, 8'h81);
        wr(`AOFTP_OFS_UPAT1_LO, 8'h5C);
        soft_reset = 1'b1;
        @(negedge sys_clk);
        soft_reset = 1'b0;
        rdchk(`AOFTP_OFS_FMT, 8'h20);
        rdchk(`AOFTP_OFS_TIMING, 8'h40);
        rdchk(`AOFTP_OFS_TEST, 8'h00);
        rdchk(`AOFTP_OFS_UPAT1_LO, 8'h00);
        $display("test soft reset done");
        rdchk(`AOFTP_OFS_CAL, 8'h00);
        cal_done_in = 1'b1;
        repeat (4) @(negedge sys_clk);
        wr(`AOFTP_OFS_CAL, 8'h00);
        rdchk(`AOFTP_OFS_CAL, 8'h01);
        $display("test calibration flag done");
        for (int j = 0; j < 3; j++)
        begin
            run(8'((j + 1) << 4), 4);
            foreach (cap.got[m]) chk(13'(cap.got[m].data), 13'(fixed_val[j]), "fixed pattern");
        end
        run(8'h40, 6);
        for (int m = 1; m < 6; m++) chk(13'(cap.got[m].data ^ cap.got[m-1].data), 13'hFFF, "alternation");
        run(8'h70, 4);
        chk(13'(cap.got[0].data ^ cap.got[1].data), 13'hFFF, "ones zeros");
        run(8'hA0, 4);
        chk(13'(cap.got[0].data === cap.got[1].data), 13'h0000, "ramp moves");
        run(8'h00, 4);
        chk(13'(cap.got[0].ddr), 13'h0000, "sdr word");
        foreach (cap.got[m]) chk(13'(cap.got[m].data), 13'(12'h123 + 12'(m)), "sample pass");
        wr(`AOFTP_OFS_FMT, 8'h22);
        run(8'h00, 2);
        chk(13'(cap.got[0].data), 13'h01B2, "gray coding");
        wr(`AOFTP_OFS_FMT, 8'h24);
        run(8'h00, 2);
        chk(13'(cap.got[0].data), 13'h0923, "offset binary coding");
        wr(`AOFTP_OFS_FMT, 8'h20);
        wr(`AOFTP_OFS_UPAT1_LO, 8'h5C);
        run(8'h80, 5);
        chk(13'(cap.got[0].data), 13'h005C, "pattern one value");
        foreach (cap.got[m]) chk(cap.got[m], cap.got[0], "pattern one only");
        slow = 1'b1;
        run(8'h81, 6);
        chk(13'(cap.got[0] === cap.got[1]), 13'h0000, "two patterns differ");
        for (int m = 2; m < 6; m++) chk(cap.got[m], cap.got[m%2], "sequence repeats");
        $display("test patterns done");
        wr(`AOFTP_OFS_TIMING, 8'h10);
        @(negedge sys_clk);
        chk({12'h000, port_cfg.ddr}, 13'h0001, "ddr config");
        run(8'h82, 6);
        chk(13'(cap.got[0].ddr), 13'h0001, "ddr word");
        for (int m = 3; m < 6; m++) chk(cap.got[m], cap.got[m%3], "odd pattern cycle");
        $display("test double rate done");
        slow = 1'b0;
        stall = 1'b1;
        wr(`AOFTP_OFS_TEST, 8'h00);
        cap.got.delete();
        sample_valid = 1'b1;
        repeat (20) @(negedge sys_clk);
        chk({12'h000, sample_ready}, 13'h0000, "fifo full");
        sample_valid = 1'b0;
        stall = 1'b0;
        repeat (30) @(negedge sys_clk);
        chk({11'h000, sample_ready, out_valid}, 13'h0002, "fifo drained");
        chk(13'(cap.got.size()), 13'(`AOFTP_FIFO_DEPTH + 1), "buffered words");
        $display("test buffer done");
        end_sim();
    end
endmodule : testbench
`default_nettype wire
